// ==== hw/bsm_pkg.sv ====
// Constants and types of the boot shadow memory map
package bsm_pkg;
   // ***************************************************
   // Address map
   // ***************************************************
   localparam logic [15:0] ROM_LO_LAST = 16'h27ff;
   localparam logic [15:0] ROM_HI_BASE = 16'h8000;
   localparam logic [15:0] ROM_HI_LAST = 16'ha7ff;
   localparam logic [15:0] RAM_LAST    = 16'h3fff;
   localparam logic [15:0] IO_FIRST    = 16'hf800;
   localparam logic [15:0] RESET_VEC   = 16'h0000;
   localparam logic [15:0] SHADOW_ADDR = 16'hff90;
   localparam logic [15:0] USB_CTL_ADDR = 16'hfffc;
   localparam int          ROM_ADDR_W  = 14;
   localparam int          RAM_ADDR_W  = 14;
   localparam int          RAM_DEPTH   = 16384;
   // ***************************************************
   // Register fields and reset values
   // ***************************************************
   localparam int         SHADOW_POS  = 0;
   localparam int         CONNECT_POS = 7;
   localparam logic [1:0] SIZE_4K     = 2'h0;
   localparam logic [1:0] SIZE_8K     = 2'h1;
   localparam logic [1:0] SIZE_16K    = 2'h2;
   localparam logic [1:0] SIZE_32K    = 2'h3;
   localparam logic       CODE_IS_RAM = 1'h1;
   localparam logic [3:0] RSVD_VALUE  = 4'h0;
   localparam logic       SHADOW_RST  = 1'h0;
   localparam logic       CONNECT_RST = 1'h0;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;
   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [2:0] {
      CODE_NONE = 3'b001,
      CODE_ROM  = 3'b010,
      CODE_RAM  = 3'b100
   } bsm_code_src_type;
   typedef enum logic [4:0] {
      X_NONE  = 5'b00001,
      X_RAM   = 5'b00010,
      X_EXT   = 5'b00100,
      X_LOCAL = 5'b01000,
      X_CTL   = 5'b10000
   } bsm_x_src_type;
   typedef struct packed {
      logic        rd;
      logic [15:0] addr;
   } bsm_code_req_type;
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } bsm_x_req_type;
   typedef struct packed {
      logic             shadow;
      logic             connect;
      bsm_code_src_type code_src;
      bsm_x_src_type    x_src;
      logic [7:0]       local_rd;
      logic             code_valid;
      logic             x_valid;
   } bsm_state_type;
endpackage

// ==== hw/bsm_ram.sv ====
// Single-port byte RAM with registered read data
`timescale 1ns/10ps
`default_nettype none
module bsm_ram #(
   parameter int DEPTH  = 16384,
   parameter int ADDR_W = 14
) (
   input  wire logic              clk,
   input  wire logic              en,
   input  wire logic              we,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [7:0]        wdata,
   output logic      [7:0]        rdata
);
   // Depth must fill the address space exactly
   if (DEPTH != (1 << ADDR_W))
   begin : g_bad
      $error("bsm_ram: DEPTH must equal 2**ADDR_W");
   end
   logic [7:0] mem [DEPTH];
   logic [7:0] rdata_q;
   // ***************************************************
   // Storage; contents are undefined until loaded
   // ***************************************************
   always_ff @(posedge clk)
   begin
      if (en && we)
      begin
         mem[addr] <= wdata;
      end
      if (en && !we)
      begin
         rdata_q <= mem[addr];
      end
   end
   assign rdata = rdata_q;
endmodule // bsm_ram
`default_nettype wire

// ==== hw/bsm_map.sv ====
// Boot shadow memory map: code/xdata decode, shadow register, connect bit
// How it works
// - Shadow clear: boot ROM at code 0000-27FF and aliased at 8000-A7FF.
// - Shadow clear: 16K RAM readable and writable at xdata 0000-3FFF.
// - Both modes: xdata F800-FFFF goes to buffers, registers and I/O.
// - Shadow set: RAM is code at 0000-3FFF, ROM only at 8000-A7FF.
// - Shadow set: every write to the code RAM is blocked.
// - Shadow bit is set by software, cleared only by reset.
// - Reserved bits 4..1 read zero, writes ignored.
// - Bits 6..5 read fixed 10b (16K code size).
// - Bit 7 reads fixed 1: code space is RAM.
// - Reset clears shadow bit and USB connect bit.
// - First fetch after reset at 0000 lands in boot ROM.
`timescale 1ns/10ps
`default_nettype none
module bsm_map (
   input  wire logic                      clk,
   input  wire logic                      reset,
   input  wire bsm_pkg::bsm_code_req_type code_req,
   output logic                           code_valid,
   output logic      [7:0]                code_rdata,
   input  wire bsm_pkg::bsm_x_req_type    x_req,
   output logic                           x_valid,
   output logic      [7:0]                x_rdata,
   output logic                           rom_rd,
   output logic      [13:0]               rom_addr,
   input  wire logic [7:0]                rom_rdata,
   output bsm_pkg::bsm_x_req_type         ext_req,
   input  wire logic [7:0]                ext_rdata,
   output logic                           shadow_enable_bit,
   output logic                           usb_connect_bit
);
   bsm_pkg::bsm_state_type st_q;
   bsm_pkg::bsm_state_type st_d;
   logic        ram_en;
   logic        ram_we;
   logic [13:0] ram_addr;
   logic [7:0]  ram_rdata;
   logic        code_rom;
   logic        code_ram;
   logic        x_ram;
   logic        x_io;
   logic        x_shd;
   logic        x_ctl;
   logic [7:0]  cfg_value;

   // ***************************************************
   // Code RAM; one port is enough since code and xdata
   // never own it in the same mode
   // ***************************************************
   bsm_ram #(
      .DEPTH  (bsm_pkg::RAM_DEPTH),
      .ADDR_W (bsm_pkg::RAM_ADDR_W)
   ) u_ram (
      .clk   (clk),
      .en    (ram_en),
      .we    (ram_we),
      .addr  (ram_addr),
      .wdata (x_req.wdata),
      .rdata (ram_rdata)
   );

   // ***************************************************
   // Address decode
   // ***************************************************
   // ROM window low is only live in boot mode; alias is always live
   always_comb
   begin
      code_rom = (!st_q.shadow && code_req.addr <= bsm_pkg::ROM_LO_LAST)
         || (code_req.addr >= bsm_pkg::ROM_HI_BASE
             && code_req.addr <= bsm_pkg::ROM_HI_LAST);
      code_ram = st_q.shadow && code_req.addr <= bsm_pkg::RAM_LAST;
      x_ram    = !st_q.shadow && x_req.addr <= bsm_pkg::RAM_LAST;
      x_io     = x_req.addr >= bsm_pkg::IO_FIRST;
      x_shd    = x_req.addr == bsm_pkg::SHADOW_ADDR;
      x_ctl    = x_req.addr == bsm_pkg::USB_CTL_ADDR;
   end

   // Read value of the shadow configuration register
   assign cfg_value = {bsm_pkg::CODE_IS_RAM, bsm_pkg::SIZE_16K,
                       bsm_pkg::RSVD_VALUE, st_q.shadow};

   // ***************************************************
   // Memory port steering
   // ***************************************************
   // The RAM port follows the mode, so an xdata write in
   // normal mode can never reach it
   always_comb
   begin
      ram_en   = 1'b0;
      ram_we   = 1'b0;
      ram_addr = x_req.addr[13:0];
      if (st_q.shadow)
      begin
         ram_en   = code_req.rd && code_ram;
         ram_addr = code_req.addr[13:0];
      end
      else
      begin
         ram_en = (x_req.rd || x_req.wr) && x_ram;
         ram_we = x_req.wr && x_ram;
      end
      rom_rd   = code_req.rd && code_rom;
      rom_addr = code_req.addr[13:0];
   end

   // Everything in the I/O window except the shadow register goes out
   always_comb
   begin
      ext_req = '0;
      if ((x_req.rd || x_req.wr) && x_io && !x_shd)
      begin
         ext_req = x_req;
      end
   end

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb
   begin
      st_d            = st_q;
      st_d.code_valid = code_req.rd;
      st_d.x_valid    = x_req.rd;
      // Read source is latched so returned data lines up
      // with the registered memories
      if (code_req.rd && code_ram)
      begin
         st_d.code_src = bsm_pkg::CODE_RAM;
      end
      else if (code_req.rd && code_rom)
      begin
         st_d.code_src = bsm_pkg::CODE_ROM;
      end
      else
      begin
         st_d.code_src = bsm_pkg::CODE_NONE;
      end
      st_d.x_src = bsm_pkg::X_NONE;
      if (x_req.rd)
      begin
         if (x_ram)
         begin
            st_d.x_src = bsm_pkg::X_RAM;
         end
         else if (x_shd)
         begin
            st_d.x_src    = bsm_pkg::X_LOCAL;
            st_d.local_rd = cfg_value;
         end
         else if (x_ctl)
         begin
            st_d.x_src    = bsm_pkg::X_CTL;
            st_d.local_rd = {st_q.connect, 7'h00};
         end
         else if (x_io)
         begin
            st_d.x_src = bsm_pkg::X_EXT;
         end
      end
      // Only bit 0 is writable, and only towards 1
      if (x_req.wr && x_shd && x_req.wdata[bsm_pkg::SHADOW_POS])
      begin
         st_d.shadow = 1'b1;
      end
      if (x_req.wr && x_ctl)
      begin
         st_d.connect = x_req.wdata[bsm_pkg::CONNECT_POS];
      end
      if (reset)
      begin
         st_d.shadow     = bsm_pkg::SHADOW_RST;
         st_d.connect    = bsm_pkg::CONNECT_RST;
         st_d.code_src   = bsm_pkg::CODE_NONE;
         st_d.x_src      = bsm_pkg::X_NONE;
         st_d.local_rd   = 8'h00;
         st_d.code_valid = 1'b0;
         st_d.x_valid    = 1'b0;
      end
   end

   // ***************************************************
   // State register
   // ***************************************************
   always_ff @(posedge clk)
   begin
      st_q <= st_d;
   end

   // ***************************************************
   // Read data return, one cycle after the request
   // ***************************************************
   // Muxes only registered sources under a registered select
   always_comb
   begin
      case (st_q.code_src)
         bsm_pkg::CODE_ROM: code_rdata = rom_rdata;
         bsm_pkg::CODE_RAM: code_rdata = ram_rdata;
         default:           code_rdata = bsm_pkg::UNMAPPED_RD;
      endcase
      case (st_q.x_src)
         bsm_pkg::X_RAM:   x_rdata = ram_rdata;
         bsm_pkg::X_EXT:   x_rdata = ext_rdata;
         bsm_pkg::X_LOCAL: x_rdata = st_q.local_rd;
         bsm_pkg::X_CTL:   x_rdata = {st_q.local_rd[7], ext_rdata[6:0]};
         default:          x_rdata = bsm_pkg::UNMAPPED_RD;
      endcase
   end

   assign code_valid        = st_q.code_valid;
   assign x_valid           = st_q.x_valid;
   assign shadow_enable_bit = st_q.shadow;
   assign usb_connect_bit   = st_q.connect;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   boot_rom_low_a: assert property (
      code_req.rd && !st_q.shadow && code_req.addr <= 16'h27ff
      |-> rom_rd && rom_addr == code_req.addr[13:0] && !ram_en)
      else $error("boot ROM low window not selected");

   rom_alias_a: assert property (
      code_req.rd && code_req.addr >= 16'h8000 && code_req.addr <= 16'ha7ff
      |-> rom_rd && rom_addr == code_req.addr[13:0])
      else $error("ROM alias window not selected");

   boot_xram_a: assert property (
      x_req.wr && !st_q.shadow && x_req.addr <= 16'h3fff
      |-> ram_we && ram_addr == x_req.addr[13:0])
      else $error("boot mode xdata write missed RAM");

   io_window_a: assert property (
      x_req.rd && x_req.addr >= 16'hf800 && x_req.addr != 16'hff90
      |-> ext_req.rd && ext_req.addr == x_req.addr)
      else $error("I/O window access not forwarded");

   code_ram_a: assert property (
      code_req.rd && st_q.shadow && code_req.addr <= 16'h3fff
      |-> ram_en && !ram_we && ram_addr == code_req.addr[13:0] && !rom_rd
      ##1 code_valid && code_rdata == ram_rdata)
      else $error("normal mode code fetch not from RAM");

   ram_write_block_a: assert property (
      st_q.shadow |-> !ram_we)
      else $error("RAM written in normal mode");

   shadow_sticky_a: assert property (
      st_q.shadow ##1 !reset |-> st_q.shadow)
      else $error("shadow bit cleared without reset");

   shadow_set_a: assert property (
      x_req.wr && x_req.addr == 16'hff90 && x_req.wdata[0] |=> st_q.shadow)
      else $error("shadow bit did not set");

   cfg_read_a: assert property (
      x_req.rd && x_req.addr == 16'hff90
      |=> x_valid && x_rdata[7:1] == 7'h60 && x_rdata[0] == $past(st_q.shadow))
      else $error("configuration register read wrong");

   reset_clear_a: assert property (disable iff (1'b0)
      reset |=> !shadow_enable_bit && !usb_connect_bit && !x_valid)
      else $error("reset did not clear shadow and connect");

   // The first fetch may come on the first or second edge after release
   first_fetch_a: assert property (
      $fell(reset) ##[0:1] (code_req.rd && code_req.addr == 16'h0000) |-> rom_rd && !ram_en)
      else $error("first fetch not from boot ROM");

   connect_write_a: assert property (
      x_req.wr && x_req.addr == 16'hfffc |=> usb_connect_bit == $past(x_req.wdata[7]))
      else $error("connect bit write lost");

   normal_xwrite_a: assert property (
      x_req.wr && st_q.shadow && x_req.addr <= 16'h3fff |-> !ram_we && !ext_req.wr)
      else $error("normal mode xdata write reached code RAM");

   normal_xread_a: assert property (
      x_req.rd && st_q.shadow && x_req.addr <= 16'h3fff |=> x_valid && x_rdata == 8'h00)
      else $error("code RAM still readable as xdata");

   shadow_hold_a: assert property (
      !st_q.shadow && !(x_req.wr && x_req.addr == 16'hff90 && x_req.wdata[0])
      |=> !st_q.shadow)
      else $error("shadow bit set without a register write");

   io_write_a: assert property (
      x_req.wr && x_req.addr >= 16'hf800 && x_req.addr != 16'hff90 |-> ext_req == x_req)
      else $error("I/O window write not forwarded");

   ext_quiet_a: assert property (
      x_req.addr < 16'hf800 || x_req.addr == 16'hff90 |-> !ext_req.rd && !ext_req.wr)
      else $error("access outside the I/O window forwarded");

   unmapped_code_a: assert property (
      code_req.rd && code_req.addr >= 16'ha800 |=> code_valid && code_rdata == 8'h00)
      else $error("unmapped code address returned data");

   // ***************************************************
   // Coverage of the main scenarios
   // ***************************************************

   boot_load_c: cover property (
      x_req.wr && !st_q.shadow && x_req.addr <= 16'h3fff);
   mode_switch_c: cover property (
      !st_q.shadow ##1 st_q.shadow ##[1:20] code_req.rd && code_req.addr == 16'h0000);
   connect_after_c: cover property (st_q.shadow ##[1:20] $rose(usb_connect_bit));
   blocked_write_c: cover property (
      st_q.shadow && x_req.wr && x_req.addr <= 16'h3fff);
endmodule // bsm_map
`default_nettype wire

// ==== bench/bsm_far_model.sv ====
// Far-side model: boot ROM and the rest of the I/O space, both with registered reads
`timescale 1ns/10ps
`default_nettype none
module bsm_far_model (
   input  wire logic                   clk,
   input  wire logic                   rom_rd,
   input  wire logic [13:0]            rom_addr,
   output logic      [7:0]             rom_rdata,
   input  wire bsm_pkg::bsm_x_req_type ext_req,
   output logic      [7:0]             ext_rdata
);
   // Arbitrary start pattern so idle data is never unknown
   initial
   begin
      rom_rdata = 8'h3c;
      ext_rdata = 8'hc3;
   end
   // Idle cycles toggle the data, so a stale byte never passes for an answer
   always @(posedge clk)
   begin
      rom_rdata <= rom_rd ? (rom_addr[7:0] ^ {2'h0, rom_addr[13:8]} ^ 8'ha5) : ~rom_rdata;
      ext_rdata <= ext_req.rd ? (ext_req.addr[7:0] ^ ext_req.addr[15:8] ^ 8'h5a) : ~ext_rdata;
   end
endmodule // bsm_far_model
`default_nettype wire

// ==== bench/tb_bsm_map.sv ====
// Self-checking bench of the boot shadow memory map
`timescale 1ns/10ps
`default_nettype none
module tb_bsm_map;
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s expected %h seen %h", n, e, g); end end
   logic                      clk = 1'b0;
   logic                      reset;
   bsm_pkg::bsm_code_req_type code_req;
   logic                      code_valid;
   logic [7:0]                code_rdata;
   bsm_pkg::bsm_x_req_type    x_req;
   logic                      x_valid;
   logic [7:0]                x_rdata;
   logic                      rom_rd;
   logic [13:0]               rom_addr;
   logic [7:0]                rom_rdata;
   bsm_pkg::bsm_x_req_type    ext_req;
   logic [7:0]                ext_rdata;
   logic                      shadow_enable_bit;
   logic                      usb_connect_bit;
   int                        fail_count;
   int                        checks_done;
   integer                    seed;
   logic                      sh_m = 1'b0;
   logic                      con_m = 1'b0;
   logic [7:0]                ram_m [int];
   logic [15:0]               a;
   logic [7:0]                d;
   logic [15:0]               edges [10] = '{16'h0000, 16'h27ff, 16'h2800, 16'h3fff, 16'h4000,
                                             16'h7fff, 16'h8000, 16'ha7ff, 16'ha800, 16'hffff};
   // ***************************************************
   // Design, far side and clock
   // ***************************************************
   bsm_map dut (.clk(clk), .reset(reset), .code_req(code_req), .code_valid(code_valid),
      .code_rdata(code_rdata), .x_req(x_req), .x_valid(x_valid), .x_rdata(x_rdata),
      .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_rdata(rom_rdata), .ext_req(ext_req),
      .ext_rdata(ext_rdata), .shadow_enable_bit(shadow_enable_bit),
      .usb_connect_bit(usb_connect_bit));
   bsm_far_model far (.clk(clk), .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_rdata(rom_rdata),
      .ext_req(ext_req), .ext_rdata(ext_rdata));
   // 100 MHz
   always #5 clk = ~clk;
   // ***************************************************
   // Expected values
   // ***************************************************
   function automatic logic [15:0] ram_a(input int k);
      return (k < 64) ? 16'(k) : 16'(16'h3f80 + k);
   endfunction
   // RAM is only read where written, so unknown cells never reach a compare
   function automatic logic [15:0] fix(input logic [15:0] ad);
      return (ad <= bsm_pkg::RAM_LAST) ? ram_a(int'(ad[6:0])) : ad;
   endfunction
   function automatic logic rom_hit(input logic [15:0] ad);
      return (ad >= bsm_pkg::ROM_HI_BASE && ad <= bsm_pkg::ROM_HI_LAST)
         || (!sh_m && ad <= bsm_pkg::ROM_LO_LAST);
   endfunction
   function automatic logic [7:0] exp_code(input logic [15:0] ad);
      if (rom_hit(ad)) return ad[7:0] ^ {2'h0, ad[13:8]} ^ 8'ha5;
      if (sh_m && ad <= bsm_pkg::RAM_LAST) return ram_m[int'(ad)];
      return bsm_pkg::UNMAPPED_RD;
   endfunction
   function automatic logic [7:0] exp_x(input logic [15:0] ad);
      logic [7:0] e;
      e = ad[7:0] ^ ad[15:8] ^ 8'h5a;
      if (ad == bsm_pkg::SHADOW_ADDR) return {1'b1, 2'h2, 4'h0, sh_m};
      if (ad == bsm_pkg::USB_CTL_ADDR) return {con_m, e[6:0]};
      if (ad >= bsm_pkg::IO_FIRST) return e;
      if (!sh_m && ad <= bsm_pkg::RAM_LAST) return ram_m[int'(ad)];
      return bsm_pkg::UNMAPPED_RD;
   endfunction
   // ***************************************************
   // Bus tasks
   // ***************************************************
   task automatic do_reset(input int n);
      @(posedge clk) reset <= 1'b1;
      repeat (n - 1) @(posedge clk);
      reset <= 1'b0;
      sh_m = 1'b0;
      con_m = 1'b0;
      #1 `CHK("shadow", 1'b0, shadow_enable_bit)
      `CHK("connect", 1'b0, usb_connect_bit)
   endtask
   task automatic cfetch(input logic [15:0] ad);
      @(posedge clk) code_req <= '{rd: 1'b1, addr: ad};
      #1 `CHK("rom_rd", rom_hit(ad), rom_rd)
      @(posedge clk) code_req <= '0;
      #1 `CHK("code_valid", 1'b1, code_valid)
      `CHK("code_rdata", exp_code(ad), code_rdata)
   endtask
   task automatic xacc(input logic wr, input logic [15:0] ad, input logic [7:0] wd);
      logic [7:0] e;
      @(posedge clk) x_req <= '{rd: !wr, wr: wr, addr: ad, wdata: wd};
      #1 `CHK("ext_req", (ad >= bsm_pkg::IO_FIRST && ad != bsm_pkg::SHADOW_ADDR) ? x_req : bsm_pkg::bsm_x_req_type'(0), ext_req)
      e = exp_x(ad);
      @(posedge clk) x_req <= '0;
      if (wr)
      begin
         if (!sh_m && ad <= bsm_pkg::RAM_LAST) ram_m[int'(ad)] = wd;
         if (ad == bsm_pkg::SHADOW_ADDR) sh_m = sh_m | wd[0];
         if (ad == bsm_pkg::USB_CTL_ADDR) con_m = wd[7];
         #1 `CHK("shadow", sh_m, shadow_enable_bit)
         `CHK("connect", con_m, usb_connect_bit)
      end
      else
      begin
         #1 `CHK("x_valid", 1'b1, x_valid)
         `CHK("x_rdata", e, x_rdata)
      end
   endtask
   task automatic final_report();
      if (fail_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Watchdog: the sequence needs well under 10000 cycles
   initial
   begin
      repeat (50000) @(posedge clk);
      fail_count++;
      final_report();
   end
   // ***************************************************
   // Main sequence: boot mode pass, then normal mode pass
   // ***************************************************
   initial
   begin
      reset = 1'b1;
      code_req = '0;
      x_req = '0;
      fail_count = 0;
      checks_done = 0;
      seed = 32'h3d42;
      do_reset(12);
      cfetch(bsm_pkg::RESET_VEC);
      // Loader copies code into both ends of the RAM through data space
      for (int k = 0; k < 128; k++)
      begin
         d = $random(seed);
         xacc(1'b1, ram_a(k), d);
      end
      for (int m = 0; m < 2; m++)
      begin
         foreach (edges[k]) cfetch(sh_m ? fix(edges[k]) : edges[k]);
         foreach (edges[k]) xacc(1'b0, fix(edges[k]), 8'h00);
         repeat (300)
         begin
            a = $random(seed);
            d = $random(seed);
            case (d[7:6])
               2'h0: cfetch(sh_m ? fix(a) : a);
               2'h1: xacc(1'b0, fix(a), d);
               2'h2: xacc(1'b0, {5'h1f, a[10:0]}, d);
               default: xacc(1'b1, fix(a), 8'($random(seed)));
            endcase
         end
         // Clearing writes and read-only bits are ignored in either mode
         repeat (4)
         begin
            d = $random(seed);
            xacc(1'b1, bsm_pkg::SHADOW_ADDR, d & 8'hfe);
            xacc(1'b0, bsm_pkg::SHADOW_ADDR, 8'h00);
         end
         if (m == 0)
         begin
            xacc(1'b1, bsm_pkg::SHADOW_ADDR, 8'h01);
            cfetch(bsm_pkg::RESET_VEC);
            xacc(1'b1, bsm_pkg::USB_CTL_ADDR, 8'h80);
            xacc(1'b0, bsm_pkg::USB_CTL_ADDR, 8'h00);
         end
      end
      // Blocked write leaves the code byte as loaded
      d = ~ram_m[9];
      xacc(1'b1, ram_a(9), d);
      cfetch(ram_a(9));
      do_reset(2);
      xacc(1'b0, bsm_pkg::SHADOW_ADDR, 8'h00);
      xacc(1'b0, bsm_pkg::USB_CTL_ADDR, 8'h00);
      cfetch(bsm_pkg::RESET_VEC);
      xacc(1'b0, ram_a(3), 8'h00);
      final_report();
   end
`undef CHK
endmodule // tb_bsm_map
`default_nettype wire
